// File: tb/prf_filter_tb_top.sv
// Bench for the physical request filter: register access and routing
`timescale 1ns/1ns
`default_nettype none
module prf_filter_tb_top;
  import prf_pkg::*;
  logic hclk, hsel, hwrite, hreadyout, hresp;
  logic hresetn = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd_q, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  prf_request_t req;
  prf_route_t route;
  int bad_count = 0;
  int num_checks = 0;
  // Transfer size for the next ahb call; a non-word write must be ignored
  logic [2:0] sz = PRF_HSIZE_WORD;
  prf_filter DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req_in(req), .route_out(route));
  prf_node_model u_node (.hclk(hclk), .req(req));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Capture read data at the sampling edge to avoid a race with its update
  always @(posedge hclk) rd_q <= hrdata;
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic tally(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : tally
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    htrans <= PRF_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1 q = rd_q;
  endtask : ahb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    tally("register", exp, q);
    tally("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk
  task automatic req_chk(input logic [9:0] bus, input logic [5:0] node, input logic acc, input logic [3:0] exp);
    u_node.send(bus, node, acc);
    #1 tally("route", {28'h0, exp}, {28'h0, route});
    @(posedge hclk);
    #1 tally("route idle", 32'h0, {28'h0, route});
  endtask : req_chk
  initial begin
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = PRF_HSIZE_WORD;
    hwdata = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(PRF_LOW_SET_ADDR, 32'h0);
    rd_chk(PRF_HIGH_CLR_ADDR, 32'h0);
    ahb(1'b1, PRF_LOW_SET_ADDR, 32'h8000_0021);
    rd_chk(PRF_LOW_CLR_ADDR, 32'h8000_0021);
    ahb(1'b1, PRF_LOW_CLR_ADDR, 32'h0000_0001);
    rd_chk(PRF_LOW_SET_ADDR, 32'h8000_0020);
    ahb(1'b1, PRF_HIGH_SET_ADDR, 32'h8004_0001);
    ahb(1'b1, PRF_HIGH_CLR_ADDR, 32'h0);
    rd_chk(PRF_HIGH_SET_ADDR, 32'h8004_0001);
    ahb(1'b1, 12'h120, 32'hffff_ffff);
    rd_chk(12'h120, 32'h0);
    sz = 3'h0;
    ahb(1'b1, PRF_LOW_SET_ADDR, 32'h0000_0001);
    sz = PRF_HSIZE_WORD;
    rd_chk(PRF_LOW_SET_ADDR, 32'h8000_0020);
    $display("Test registers done");
    req_chk(PRF_LOCAL_BUS_ID, 6'd5, 1'b1, 4'hc);
    req_chk(PRF_LOCAL_BUS_ID, 6'd0, 1'b1, 4'ha);
    req_chk(PRF_LOCAL_BUS_ID, 6'd31, 1'b1, 4'hc);
    req_chk(PRF_LOCAL_BUS_ID, 6'd5, 1'b0, 4'h9);
    req_chk(PRF_LOCAL_BUS_ID, 6'd32, 1'b1, 4'hc);
    req_chk(PRF_LOCAL_BUS_ID, 6'd50, 1'b1, 4'hc);
    req_chk(PRF_LOCAL_BUS_ID, 6'd49, 1'b1, 4'ha);
    req_chk(PRF_LOCAL_BUS_ID, 6'd51, 1'b1, 4'ha);
    req_chk(PRF_LOCAL_BUS_ID, PRF_BCAST_NODE, 1'b1, 4'ha);
    req_chk(10'h001, 6'd5, 1'b1, 4'hc);
    ahb(1'b1, PRF_HIGH_CLR_ADDR, 32'h8000_0000);
    req_chk(10'h001, 6'd5, 1'b1, 4'ha);
    $display("Test routing done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(PRF_LOW_SET_ADDR, 32'h0);
    rd_chk(PRF_HIGH_SET_ADDR, 32'h0);
    req_chk(PRF_LOCAL_BUS_ID, 6'd5, 1'b1, 4'ha);
    $display("Test reset done");
    finish_test();
  end
  // The run needs under 10 us; allow twenty times that
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule : prf_filter_tb_top
`default_nettype wire

// File: tb/prf_node_model.sv
// Remote node model: issues one-cycle physical requests
`timescale 1ns/1ns
`default_nettype none
module prf_node_model
  import prf_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Request to the filter
  output prf_request_t req
);
  initial req = '0;
  // Idle fields flip so stale values never look valid
  task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic acc);
    @(posedge hclk);
    req <= '{1'b1, bus, node, acc};
    @(posedge hclk);
    req <= '{1'b0, ~bus, ~node, ~acc};
  endtask : send
endmodule : prf_node_model
`default_nettype wire

// File: verilog/prf_filter.sv
// Physical request filter: set/clear mask words on AHB-Lite and the per-request routing decision
`timescale 1ns/1ns
`default_nettype none
module prf_filter
  import prf_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Incoming physical request and its routing
  input wire prf_request_t req_in,
  output prf_route_t route_out
);

  logic [31:0] low_reg;
  logic [31:0] low_next;
  logic [31:0] high_reg;
  logic [31:0] high_next;
  logic wr_pend_reg;
  logic [PRF_ADDR_W-1:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  prf_route_t route_reg;
  prf_route_t route_next;

  // Address phase decode
  wire addr_phase = hsel && hready && (htrans == PRF_HTRANS_NONSEQ || htrans == PRF_HTRANS_SEQ);
  wire [PRF_ADDR_W-1:0] a_addr = haddr[PRF_ADDR_W-1:0];
  wire rd_start = addr_phase && !hwrite;
  wire wr_start = addr_phase && hwrite && hsize == PRF_HSIZE_WORD;

  // Data phase write strobes, one per alias
  wire wr_low_set = wr_pend_reg && wr_addr_reg == PRF_LOW_SET_ADDR;
  wire wr_low_clr = wr_pend_reg && wr_addr_reg == PRF_LOW_CLR_ADDR;
  wire wr_high_set = wr_pend_reg && wr_addr_reg == PRF_HIGH_SET_ADDR;
  wire wr_high_clr = wr_pend_reg && wr_addr_reg == PRF_HIGH_CLR_ADDR;

  // Only ones act; zero bits keep their value
  assign low_next = wr_low_set ? (low_reg | hwdata) :
                    wr_low_clr ? (low_reg & ~hwdata) : low_reg;
  assign high_next = wr_high_set ? (high_reg | hwdata) :
                     wr_high_clr ? (high_reg & ~hwdata) : high_reg;

  // Read data is taken from the next value so a read right behind a write sees it
  wire rd_low = a_addr == PRF_LOW_SET_ADDR || a_addr == PRF_LOW_CLR_ADDR;
  wire rd_high = a_addr == PRF_HIGH_SET_ADDR || a_addr == PRF_HIGH_CLR_ADDR;
  assign hrdata_next = !rd_start ? 32'h0000_0000 :
                       rd_low ? low_next :
                       rd_high ? high_next : 32'h0000_0000;

  // Flatten the two words into one enable per node, node n at index n
  logic [PRF_NODE_COUNT-1:0] node_phys_enable_bit;
  genvar gi;
  generate
    for (gi = 0; gi < PRF_NODE_COUNT; gi = gi + 1) begin : g_node
      if (gi < PRF_HIGH_NODE_BASE) begin : g_low
        assign node_phys_enable_bit[gi] = low_reg[gi];
      end else begin : g_high
        assign node_phys_enable_bit[gi] = high_reg[gi - PRF_HIGH_NODE_BASE];
      end
    end
  endgenerate

  // Broadcast node 63 has no enable bit and is never physical on the local bus
  wire is_local = req_in.bus_id == PRF_LOCAL_BUS_ID;
  wire node_ok = req_in.node != PRF_BCAST_NODE && node_phys_enable_bit[req_in.node];
  // Remote requests never consult the node bits: a node number means nothing off the local bus
  wire all_remote_busses_enable = high_reg[PRF_ALL_REMOTE_BIT];
  wire phys_hit = is_local ? node_ok : all_remote_busses_enable;

  // The async filter decides first; only its survivors meet the physical mask
  always_comb begin
    route_next.valid = req_in.valid;
    route_next.dropped = req_in.valid && !req_in.async_accept;
    route_next.to_phys = req_in.valid && req_in.async_accept && phys_hit;
    route_next.to_async = req_in.valid && req_in.async_accept && !phys_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_reg <= PRF_LOW_RESET;
      high_reg <= PRF_HIGH_RESET;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      // Address is captured every cycle; only wr_pend_reg makes it a write
      wr_pend_reg <= wr_start;
      wr_addr_reg <= a_addr;
      hrdata_reg <= hrdata_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_reg <= '0;
    end else begin
      route_reg <= route_next;
    end
  end

  // Zero wait states and always OKAY: every access completes in its first data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign route_out = route_reg;

  // Checks
  low_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> low_reg == PRF_LOW_RESET)
    else $error("low filter word not zero after reset");

  high_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> high_reg == PRF_HIGH_RESET)
    else $error("high filter word not zero after reset");

  low_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low_set |=> low_reg == ($past(low_reg) | $past(hwdata)))
    else $error("low set write did not OR in the ones");

  low_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low_clr |=> low_reg == ($past(low_reg) & ~$past(hwdata)))
    else $error("low clear write did not clear the ones");

  high_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_high_set |=> high_reg == ($past(high_reg) | $past(hwdata)))
    else $error("high set write did not OR in the ones");

  high_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_high_clr |=> high_reg == ($past(high_reg) & ~$past(hwdata)))
    else $error("high clear write did not clear the ones");

  low_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_low_set && !wr_low_clr |=> $stable(low_reg))
    else $error("low filter word changed without a write to it");

  high_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_high_set && !wr_high_clr |=> $stable(high_reg))
    else $error("high filter word changed without a write to it");

  low_node_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && is_local && req_in.node < PRF_HIGH_NODE_BASE
    |=> route_out.to_phys == $past(low_reg[req_in.node[4:0]]))
    else $error("low node routing does not follow its bit");

  high_node_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && is_local
    && req_in.node >= PRF_HIGH_NODE_BASE && req_in.node != PRF_BCAST_NODE
    |=> route_out.to_phys == $past(high_reg[req_in.node[4:0]]))
    else $error("high node routing does not follow its bit");

  phys_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && phys_hit
    |=> route_out.valid && route_out.to_phys && !route_out.to_async)
    else $error("enabled request not sent to physical context");

  async_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && !req_in.async_accept |=> route_out.dropped && !route_out.to_phys && !route_out.to_async)
    else $error("request rejected by async filter was routed");

  async_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && !phys_hit |=> route_out.to_async && !route_out.to_phys)
    else $error("disabled request not sent to async receive context");

  remote_bus_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && !is_local
    |=> route_out.to_phys == $past(high_reg[PRF_ALL_REMOTE_BIT]))
    else $error("remote bus request ignores the all-bus enable");

  bcast_node_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_in.valid && req_in.async_accept && is_local && req_in.node == PRF_BCAST_NODE
    |=> route_out.to_async && !route_out.to_phys)
    else $error("broadcast node request not sent to async receive context");

  route_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    route_out.valid |-> $onehot({route_out.to_phys, route_out.to_async, route_out.dropped}))
    else $error("valid route does not name exactly one destination");

  route_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !req_in.valid |=> route_out == '0)
    else $error("route output active without a request");

  alias_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start && rd_low && !wr_pend_reg |=> hrdata == $past(low_reg))
    else $error("low word alias read returned wrong value");

  high_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start && rd_high && !wr_pend_reg |=> hrdata == $past(high_reg))
    else $error("high word alias read returned wrong value");

endmodule : prf_filter
`default_nettype wire

// File: verilog/prf_pkg.sv
// Package for the physical request filter: register map, field layout and request carriers
package prf_pkg;
  // Register byte addresses: each word has a set and a clear alias
  localparam logic [11:0] PRF_HIGH_SET_ADDR = 12'h110;
  localparam logic [11:0] PRF_HIGH_CLR_ADDR = 12'h114;
  localparam logic [11:0] PRF_LOW_SET_ADDR = 12'h118;
  localparam logic [11:0] PRF_LOW_CLR_ADDR = 12'h11c;
  localparam int PRF_ADDR_W = 12;
  localparam logic [31:0] PRF_LOW_RESET = 32'h0000_0000;
  localparam logic [31:0] PRF_HIGH_RESET = 32'h0000_0000;
  // High word layout: bits 30..0 are nodes 62..32, bit 31 accepts every remote bus
  localparam int PRF_ALL_REMOTE_BIT = 31;
  localparam int PRF_HIGH_NODE_BASE = 32;
  localparam int PRF_NODE_COUNT = 63;
  // Source node ID: 10-bit bus number over 6-bit node number
  localparam logic [9:0] PRF_LOCAL_BUS_ID = 10'h3ff;
  localparam logic [5:0] PRF_BCAST_NODE = 6'h3f;
  // AHB encodings
  localparam logic [1:0] PRF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PRF_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PRF_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic valid;
    logic [9:0] bus_id;
    logic [5:0] node;
    logic async_accept;
  } prf_request_t;

  typedef struct packed {
    logic valid;
    logic to_phys;
    logic to_async;
    logic dropped;
  } prf_route_t;
endpackage : prf_pkg
